// ### core/rtcifs_regs.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  RTC interrupt flag and status block. Assumes a 100 MHz clock.
*/
`ifndef RTCIFS_REGS_VH
`define RTCIFS_REGS_VH

// Register indices on the plain register port (byte-wide data).
`define RTCIFS_ADDR_W          4
`define RTCIFS_OFF_RATE        4'h0
`define RTCIFS_OFF_CTRL        4'h1
`define RTCIFS_OFF_FLAGS       4'h2
`define RTCIFS_OFF_VALID       4'h3
`define RTCIFS_OFF_EVT_STAT    4'h4
`define RTCIFS_OFF_EVT_MASK    4'h5

// Rate register: divider_control in [6:4], rate_select in [3:0].
`define RTCIFS_RS_LO           0
`define RTCIFS_RS_HI           3
`define RTCIFS_DV_LO           4
`define RTCIFS_DV_HI           6
`define RTCIFS_DV_RUN          3'h2
`define RTCIFS_DV_HOLD_HI      2'h3

// Control register bits.
`define RTCIFS_B_SET           7
`define RTCIFS_B_PIE           6
`define RTCIFS_B_AIE           5
`define RTCIFS_B_UIE           4

// Flag register bits.
`define RTCIFS_B_IRQ_SUMMARY_FLAG          7
`define RTCIFS_B_PF            6
`define RTCIFS_B_AF            5
`define RTCIFS_B_UF            4

// Validity register bit.
`define RTCIFS_B_VRT           7

// Event status bits: 0 periodic, 1 alarm, 2 update done, 3 flags read.
`define RTCIFS_NEVT            4

`define RTCIFS_RST_BYTE        8'h00
`define RTCIFS_RST_EVT         4'h0

// Timing: release and oscillator start figures, counts at 10 ns per cycle.
`define RTCIFS_CLK_NS          10
`define RTCIFS_T_IRQ_REL_US    2
`define RTCIFS_IRQ_REL_CYC     ((`RTCIFS_T_IRQ_REL_US * 1000) / `RTCIFS_CLK_NS)
`define RTCIFS_T_OSC_START_MS  1000
`define RTCIFS_OSC_START_CYC   ((`RTCIFS_T_OSC_START_MS * 1000000) / `RTCIFS_CLK_NS)
`define RTCIFS_OSC_CNT_W       27

`endif

// ### core/rtcifs_tap_select.v
/*
  Periodic tap selector: picks a divider-chain tap by rate select and
  pulses one cycle on each rising edge of that tap.
  Assumes the divider chain taps are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcifs_regs.vh"

module rtcifs_tap_select (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] div_taps,
  input  wire [3:0]  rate_select,
  input  wire        chain_run,
  output reg         tap_edge
);

  reg tap_d_r;
  wire tap_now;

  // Select zero disables the output; index 0 of the tap bus is unused.
  assign tap_now = (rate_select != 4'h0) & chain_run & div_taps[rate_select];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tap_d_r  <= 1'b0;
      tap_edge <= 1'b0;
    end else begin
      tap_d_r  <= tap_now;
      tap_edge <= tap_now & ~tap_d_r; // [RULE_04]
    end
  end

endmodule // rtcifs_tap_select
`default_nettype wire

// ### core/rtcifs_osc_ctrl.v
/*
  Oscillator and countdown chain control from the divider-control bits.
  Assumes the oscillator stable indication may come late or never.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcifs_regs.vh"

module rtcifs_osc_ctrl #(
  parameter [`RTCIFS_OSC_CNT_W-1:0] OSC_START_CYC = `RTCIFS_OSC_START_CYC
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire [2:0] divider_control,
  input  wire       osc_stable,
  output reg        osc_enable,
  output reg        osc_running,
  output reg        chain_run
);

  reg  [`RTCIFS_OSC_CNT_W-1:0] start_cnt_r;
  wire                         osc_on;

  assign osc_on = (divider_control == `RTCIFS_DV_RUN) |
                  (divider_control[2:1] == `RTCIFS_DV_HOLD_HI);

  // The running flag is forced after the start limit so that software
  // never waits past it, even with a slow stable indication.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_enable  <= 1'b0;
      osc_running <= 1'b0;
      chain_run   <= 1'b0;
      start_cnt_r <= {`RTCIFS_OSC_CNT_W{1'b0}};
    end else begin
      osc_enable <= osc_on; // [RULE_15]
      if (!osc_on) begin
        start_cnt_r <= {`RTCIFS_OSC_CNT_W{1'b0}};
        osc_running <= 1'b0;
      end else if (osc_stable || start_cnt_r >= OSC_START_CYC - 1'b1) begin
        osc_running <= 1'b1; // [RULE_14]
      end else begin
        start_cnt_r <= start_cnt_r + 1'b1;
      end
      chain_run <= osc_running & (divider_control == `RTCIFS_DV_RUN); // [RULE_15]
    end
  end

endmodule // rtcifs_osc_ctrl
`default_nettype wire

// ### core/rtcifs_top.v
/*
  RTC interrupt flag and status block: event flags, enables, summary
  request flag, active-low interrupt pin and backup validity byte.
  Assumes synchronous one-cycle event pulses and a plain register port
  with read data in the cycle after the read strobe.
*/
//
// Operation
// RULE_01: Summary flag is set when any event flag and its enable are both one.
// RULE_02: Interrupt pin is low while the summary flag reads one.
// RULE_03: Reading the flag byte or reset clears every flag in it.
// RULE_04: Periodic flag sets on an edge of the rate-selected divider tap.
// RULE_05: Periodic flag sets regardless of its enable; enable only gates the request.
// RULE_06: Alarm flag sets on time match; requests only when alarm enable set.
// RULE_07: Update flag sets after each update; requests only when enabled.
// RULE_08: Low four bits of the flag byte read zero and ignore writes.
// RULE_09: Validity top bit is read only and reads one while backup is sound.
// RULE_10: Validity bit reads zero when the backup source is exhausted.
// RULE_11: Lower seven validity bits read zero and are not writable.
// RULE_12: Interrupt pin releases within 2 us after a flag byte read.
// RULE_13: Interrupt pin releases within 2 us after reset goes low.
// RULE_14: Oscillator runs within 1 s after software enables it.
// RULE_15: Divider value 010 runs the chain; 11X runs oscillator, holds chain.
// RULE_16: Update enable clears when set-mode is written high or on reset.
// RULE_17: An event in the same cycle as a flag read stays set.
`timescale 1ns/1ps
`default_nettype none
`include "rtcifs_regs.vh"

module rtcifs_top #(
  parameter [`RTCIFS_OSC_CNT_W-1:0] OSC_START_CYC = `RTCIFS_OSC_START_CYC
) (
  input  wire                      clk,
  input  wire                      nrst,
  input  wire [`RTCIFS_ADDR_W-1:0] reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  input  wire [15:0]               div_taps,
  input  wire                      alarm_match,
  input  wire                      update_done,
  input  wire                      backup_ok,
  input  wire                      osc_stable,
  output reg                       irq_n,
  output reg                       event_irq,
  output reg                       osc_enable,
  output reg                       osc_running,
  output reg                       chain_run,
  output reg                       set_mode
);

  reg  [7:0]              rate_r;
  reg  [7:0]              ctrl_r;
  reg                     periodic_flag_r;
  reg                     alarm_flag_r;
  reg                     update_done_flag_r;
  reg                     valid_r;
  reg  [`RTCIFS_NEVT-1:0] evt_stat_r;
  reg  [`RTCIFS_NEVT-1:0] evt_mask_r;
  reg  [7:0]              rdata_nxt;

  wire                    periodic_evt;
  wire                    osc_en_w;
  wire                    osc_run_w;
  wire                    chain_w;
  wire                    flags_rd;
  wire                    periodic_irq_enable;
  wire                    alarm_irq_enable;
  wire                    update_done_irq_enable;
  wire                    irq_summary_flag;
  wire [7:0]              flags_byte;
  wire [7:0]              valid_byte;
  wire [`RTCIFS_NEVT-1:0] evt_src;

  rtcifs_osc_ctrl #(
    .OSC_START_CYC   (OSC_START_CYC)
  ) u_osc (
    .clk             (clk),
    .nrst            (nrst),
    .divider_control (rate_r[`RTCIFS_DV_HI:`RTCIFS_DV_LO]),
    .osc_stable      (osc_stable),
    .osc_enable      (osc_en_w),
    .osc_running     (osc_run_w),
    .chain_run       (chain_w)
  );

  rtcifs_tap_select u_tap (
    .clk         (clk),
    .nrst        (nrst),
    .div_taps    (div_taps),
    .rate_select (rate_r[`RTCIFS_RS_HI:`RTCIFS_RS_LO]),
    .chain_run   (chain_w),
    .tap_edge    (periodic_evt)
  );

  assign flags_rd               = reg_rd & (reg_addr == `RTCIFS_OFF_FLAGS);
  assign periodic_irq_enable    = ctrl_r[`RTCIFS_B_PIE];
  assign alarm_irq_enable       = ctrl_r[`RTCIFS_B_AIE];
  assign update_done_irq_enable = ctrl_r[`RTCIFS_B_UIE];

  assign irq_summary_flag = (periodic_flag_r & periodic_irq_enable) |
                            (alarm_flag_r & alarm_irq_enable) |
                            (update_done_flag_r & update_done_irq_enable); // [RULE_01]

  // Low nibble is tied to zero and never stored, so writes cannot reach it.
  assign flags_byte = {irq_summary_flag, periodic_flag_r, alarm_flag_r,
                       update_done_flag_r, 4'h0}; // [RULE_08]
  assign valid_byte = {valid_r, 7'h00}; // [RULE_11]

  assign evt_src = {flags_rd, update_done, alarm_match, periodic_evt};

  // Control registers. Flag and validity bytes take no write at all.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_r <= `RTCIFS_RST_BYTE;
      ctrl_r <= `RTCIFS_RST_BYTE; // [RULE_16]
    end else if (reg_wr) begin
      if (reg_addr == `RTCIFS_OFF_RATE) begin
        rate_r <= {1'b0, reg_wdata[6:0]};
      end
      if (reg_addr == `RTCIFS_OFF_CTRL) begin
        ctrl_r <= reg_wdata;
        if (reg_wdata[`RTCIFS_B_SET]) begin
          ctrl_r[`RTCIFS_B_UIE] <= 1'b0; // [RULE_16]
        end
      end
    end
  end

  // Event flags: a read clears, but an event in the same cycle wins.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodic_flag_r    <= 1'b0; // [RULE_03]
      alarm_flag_r       <= 1'b0;
      update_done_flag_r <= 1'b0;
    end else begin
      periodic_flag_r    <= periodic_evt | (periodic_flag_r & ~flags_rd); // [RULE_04] [RULE_05] [RULE_17]
      alarm_flag_r       <= alarm_match | (alarm_flag_r & ~flags_rd); // [RULE_06] [RULE_17]
      update_done_flag_r <= update_done | (update_done_flag_r & ~flags_rd); // [RULE_07] [RULE_17]
    end
  end

  // Validity is sampled each cycle; reset value is zero until first sample.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= backup_ok; // [RULE_09] [RULE_10]
    end
  end

  // Block event status: write one to clear, a new event wins over the clear.
  genvar gi;
  generate
    for (gi = 0; gi < `RTCIFS_NEVT; gi = gi + 1) begin : g_evt
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          evt_stat_r[gi] <= 1'b0;
        end else if (evt_src[gi]) begin
          evt_stat_r[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == `RTCIFS_OFF_EVT_STAT && reg_wdata[gi]) begin
          evt_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_mask_r <= `RTCIFS_RST_EVT;
    end else if (reg_wr && reg_addr == `RTCIFS_OFF_EVT_MASK) begin
      evt_mask_r <= reg_wdata[`RTCIFS_NEVT-1:0];
    end
  end

  always @* begin
    rdata_nxt = `RTCIFS_RST_BYTE;
    case (reg_addr)
      `RTCIFS_OFF_RATE:     rdata_nxt = rate_r;
      `RTCIFS_OFF_CTRL:     rdata_nxt = ctrl_r;
      `RTCIFS_OFF_FLAGS:    rdata_nxt = flags_byte;
      `RTCIFS_OFF_VALID:    rdata_nxt = valid_byte;
      `RTCIFS_OFF_EVT_STAT: rdata_nxt = {4'h0, evt_stat_r};
      `RTCIFS_OFF_EVT_MASK: rdata_nxt = {4'h0, evt_mask_r};
      default:              rdata_nxt = `RTCIFS_RST_BYTE;
    endcase
  end

  // The pin follows the summary flag one cycle late, well inside the
  // release limit after a read; reset drives it high at once.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata   <= `RTCIFS_RST_BYTE;
      irq_n       <= 1'b1; // [RULE_13]
      event_irq   <= 1'b0;
      osc_enable  <= 1'b0;
      osc_running <= 1'b0;
      chain_run   <= 1'b0;
      set_mode    <= 1'b0;
    end else begin
      reg_rdata   <= reg_rd ? rdata_nxt : `RTCIFS_RST_BYTE;
      irq_n       <= ~irq_summary_flag; // [RULE_02] [RULE_12]
      event_irq   <= |(evt_stat_r & evt_mask_r);
      osc_enable  <= osc_en_w;
      osc_running <= osc_run_w;
      chain_run   <= chain_w;
      set_mode    <= ctrl_r[`RTCIFS_B_SET];
    end
  end

endmodule // rtcifs_top
`default_nettype wire

// ### tb/rtcifs_props.sv
/*
  Port checker for rtcifs_top: flags, interrupt pin, status bytes, oscillator.
  Bound to every rtcifs_top instance; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcifs_regs.vh"

module rtcifs_props #(
  parameter [`RTCIFS_OSC_CNT_W-1:0] OSC_START_CYC = `RTCIFS_OSC_START_CYC
) (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic [`RTCIFS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      alarm_match,
  input wire logic                      update_done,
  input wire logic                      backup_ok,
  input wire logic                      irq_n,
  input wire logic                      osc_enable,
  input wire logic                      osc_running,
  input wire logic                      chain_run
);
  logic [2:0]                   en_r;
  logic [`RTCIFS_OSC_CNT_W-1:0] osc_cnt_r;

  // Shadow of the enables; a write with set mode high always drops the update enable.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r      <= 3'h0;
      osc_cnt_r <= '0;
    end else begin
      if (reg_wr && reg_addr == `RTCIFS_OFF_CTRL) begin
        en_r <= {reg_wdata[6:5], reg_wdata[4] & ~reg_wdata[7]};
      end
      osc_cnt_r <= (osc_enable && !osc_running) ? osc_cnt_r + 1'b1 : '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  // A new event in the read cycle would legally keep the pin low.
  sequence s_quiet_rd;
    reg_rd && reg_addr == `RTCIFS_OFF_FLAGS && !alarm_match && !update_done;
  endsequence

  a_flags_low_zero: assert property (
    s_rd(`RTCIFS_OFF_FLAGS) |=> reg_rdata[3:0] == 4'h0) else $error("flag byte low bits set");
  a_valid_byte: assert property (
    s_rd(`RTCIFS_OFF_VALID) |=> reg_rdata == {$past(backup_ok, 2), 7'h00})
    else $error("validity byte wrong");
  a_alarm_irq: assert property (
    alarm_match && en_r[1] |-> ##2 !irq_n) else $error("alarm did not pull the pin");
  a_update_irq: assert property (
    update_done && en_r[0] |-> ##2 !irq_n) else $error("update did not pull the pin");
  a_irq_cause: assert property (
    $fell(irq_n) |-> $past(en_r) != 3'h0) else $error("pin pulled with no enable");
  a_read_release: assert property (
    s_quiet_rd |-> ##2 irq_n) else $error("pin held after flag read");
  a_reset_release: assert property (
    disable iff (1'b0) !nrst |-> irq_n) else $error("pin low in reset");
  a_osc_start: assert property (
    osc_cnt_r <= OSC_START_CYC + 2) else $error("oscillator start too slow");
  a_chain_hold: assert property (
    chain_run |-> osc_running && osc_enable) else $error("chain runs without oscillator");
endmodule // rtcifs_props

bind rtcifs_top rtcifs_props #(.OSC_START_CYC(OSC_START_CYC)) rtcifs_props_inst (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_match(alarm_match),
  .update_done(update_done), .backup_ok(backup_ok), .irq_n(irq_n),
  .osc_enable(osc_enable), .osc_running(osc_running), .chain_run(chain_run));
`default_nettype wire

// ### tb/rtcifs_host.sv
/*
  Host processor model on the register port: one-cycle write and read strobes.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcifs_host (
  input  wire logic       clk,
  output logic [3:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released lines show the inverse so that a stale value is never mistaken for a hold.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // rtcifs_host
`default_nettype wire

// ### tb/rtc_interrupt_status_flags_test.sv
/*
  Self-checking bench for rtcifs_top with the host model on its register port.
  Assumes the bound checker and a shortened oscillator start count.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcifs_regs.vh"

module rtc_interrupt_status_flags_test;
  logic        clk = 1'b0;
  logic        nrst = 1'b1;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd_d;
  logic        reg_wr, reg_rd, irq_n, event_irq, osc_enable, osc_running, chain_run;
  logic        set_mode;
  logic        osc_stable = 1'b0;
  logic [15:0] div_taps = 16'h0000;
  logic        alarm_match = 1'b0;
  logic        update_done = 1'b0;
  logic        backup_ok = 1'b1;
  int          error_cnt = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  rtcifs_top #(.OSC_START_CYC(27'd20)) rtcifs_top_inst (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .div_taps(div_taps), .alarm_match(alarm_match),
    .update_done(update_done), .backup_ok(backup_ok), .osc_stable(osc_stable), .irq_n(irq_n),
    .event_irq(event_irq), .osc_enable(osc_enable), .osc_running(osc_running),
    .chain_run(chain_run), .set_mode(set_mode));
  rtcifs_host rtcifs_host_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task stop_test;
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    rtcifs_host_inst.rd(a, rd_d);
    chk(rd_d, exp);
  endtask

  task ev(input logic alarm);
    @(posedge clk);
    alarm_match <= alarm;
    update_done <= !alarm;
    @(posedge clk);
    alarm_match <= 1'b0;
    update_done <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task t_alarm;
    rdchk(4'hf, 8'h00);
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h20);
    ev(1'b1);
    chk({7'h00, irq_n}, 8'h00);
    rdchk(`RTCIFS_OFF_FLAGS, 8'ha0);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq_n}, 8'h01);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h00);
  endtask

  task t_update;
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h00);
    ev(1'b0);
    chk({7'h00, irq_n}, 8'h01);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h10);
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h90);
    rdchk(`RTCIFS_OFF_CTRL, 8'h80);
    ev(1'b0);
    chk({7'h00, irq_n}, 8'h01);
    chk({7'h00, set_mode}, 8'h01);
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h10);
    ev(1'b0);
    chk({6'h00, set_mode, irq_n}, 8'h00);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h90);
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h00);
  endtask

  task t_periodic;
    int i;
    rtcifs_host_inst.wr(`RTCIFS_OFF_RATE, 8'h23);
    for (i = 0; i < 100 && chain_run !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, chain_run}, 8'h01);
    if (chain_run !== 1'b1) stop_test;
    @(posedge clk);
    div_taps <= 16'h0008;
    repeat (4) @(posedge clk);
    div_taps <= 16'h0000;
    #1 chk({7'h00, irq_n}, 8'h01);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h40);
    rtcifs_host_inst.wr(`RTCIFS_OFF_RATE, 8'h63);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, osc_enable, chain_run}, 8'h02);
    rtcifs_host_inst.wr(`RTCIFS_OFF_RATE, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, osc_enable, osc_running}, 8'h00);
    @(posedge clk);
    osc_stable <= 1'b1;
    rtcifs_host_inst.wr(`RTCIFS_OFF_RATE, 8'h63);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, osc_enable, osc_running}, 8'h03);
  endtask

  task t_misc;
    fork
      rtcifs_host_inst.rd(`RTCIFS_OFF_FLAGS, rd_d);
      begin
        @(posedge clk);
        alarm_match <= 1'b1;
        @(posedge clk);
        alarm_match <= 1'b0;
      end
    join
    chk(rd_d, 8'h00);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h20);
    rtcifs_host_inst.wr(`RTCIFS_OFF_VALID, 8'h00);
    rdchk(`RTCIFS_OFF_VALID, 8'h80);
    @(posedge clk);
    backup_ok <= 1'b0;
    rtcifs_host_inst.wr(`RTCIFS_OFF_VALID, 8'hff);
    rtcifs_host_inst.wr(`RTCIFS_OFF_FLAGS, 8'hff);
    rdchk(`RTCIFS_OFF_VALID, 8'h00);
    rdchk(`RTCIFS_OFF_FLAGS, 8'h00);
    @(posedge clk);
    backup_ok <= 1'b1;
  endtask

  task t_events;
    rtcifs_host_inst.wr(`RTCIFS_OFF_EVT_STAT, 8'h0f);
    rtcifs_host_inst.wr(`RTCIFS_OFF_EVT_MASK, 8'h02);
    ev(1'b1);
    chk({7'h00, event_irq}, 8'h01);
    rdchk(`RTCIFS_OFF_EVT_STAT, 8'h02);
    rtcifs_host_inst.wr(`RTCIFS_OFF_EVT_STAT, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, event_irq}, 8'h00);
    rtcifs_host_inst.wr(`RTCIFS_OFF_EVT_MASK, 8'h00);
    ev(1'b1);
    chk({7'h00, event_irq}, 8'h00);
  endtask

  task t_reset;
    rtcifs_host_inst.wr(`RTCIFS_OFF_CTRL, 8'h20);
    ev(1'b1);
    chk({7'h00, irq_n}, 8'h00);
    nrst <= 1'b0;
    #1 chk({7'h00, irq_n}, 8'h01);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdchk(`RTCIFS_OFF_FLAGS, 8'h00);
    ev(1'b1);
    chk({7'h00, irq_n}, 8'h01);
  endtask

  // Reset falls by a non-blocking write at time zero, after every process
  // waits on it, so the asynchronous reset sees a real edge before any clock.
  initial begin
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_alarm;
    t_update;
    t_periodic;
    t_misc;
    t_events;
    t_reset;
    stop_test;
  end
endmodule // rtc_interrupt_status_flags_test
`default_nettype wire
